/* design/pji_pkg.sv */
package pji_pkg;

    // Instruction register width and codes
    localparam int           IR_W           = 8;
    localparam logic [7:0]   INS_BYPASS     = 8'hFF;
    localparam logic [7:0]   INS_SAMPLE     = 8'h01;
    localparam logic [7:0]   INS_EXTEST     = 8'h00;
    localparam logic [7:0]   INS_CLAMP      = 8'hFA;
    localparam logic [7:0]   INS_HIGHZ      = 8'hFC;
    localparam logic [7:0]   INS_IDCODE     = 8'hFE;
    localparam logic [7:0]   INS_USERCODE   = 8'hFD;
    localparam logic [7:0]   INS_RESTART    = 8'hEE;
    // Capture pattern fields
    localparam int           CAP_ISP_BIT    = 4;
    localparam int           CAP_PROT_BIT   = 3;
    localparam logic [7:0]   CAP_BASE       = 8'h01;
    // Identification defaults; the id value is arbitrary
    localparam logic [31:0]  IDCODE_DEF     = 32'h0A5A5001;
    localparam logic [31:0]  USERCODE_BLANK = 32'hFFFFFFFF;
    // Restart pulse timing on the 10 MHz clock
    localparam int           CLK_NS         = 100;
    localparam int           RST_PULSE_MIN_NS = 300;
    localparam int           RST_PULSE_MAX_NS = 500;
    localparam int           RST_PULSE_CYC  = (RST_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int           ISR_W          = 4;

    // APB offsets
    localparam logic [7:0]   OFS_CTRL       = 8'h00;
    localparam logic [7:0]   OFS_STAT       = 8'h04;
    localparam logic [7:0]   OFS_USER       = 8'h08;
    localparam logic [7:0]   OFS_INS        = 8'h0C;
    // Control bit positions
    localparam int           CTL_ISP        = 0;
    localparam int           CTL_PROT_SET   = 1;
    localparam int           CTL_ERASE      = 2;

    // Decoded instruction group
    typedef struct packed {
        logic byp;
        logic bscan;
        logic idc;
        logic usr;
        logic hiz;
        logic clamp;
        logic restart;
    } pji_dec_t;

    // TAP states, one-hot
    typedef enum logic [15:0] {
        TLR  = 16'h0001, RTI  = 16'h0002, SDRS = 16'h0004, CDR  = 16'h0008,
        SDR  = 16'h0010, E1DR = 16'h0020, PDR  = 16'h0040, E2DR = 16'h0080,
        UDR  = 16'h0100, SIRS = 16'h0200, CIR  = 16'h0400, SIR  = 16'h0800,
        E1IR = 16'h1000, PIR  = 16'h2000, E2IR = 16'h4000, UIR  = 16'h8000
    } pji_tap_t;

endpackage : pji_pkg

/* design/pji_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pji_top
    import pji_pkg::*;
#(
    parameter logic [31:0] ID_VALUE = IDCODE_DEF          // Arbitrary identity value
) (
    input  wire logic        pclk,              // APB clock, 10 MHz
    input  wire logic        presetn,           // Async reset, active low
    input  wire logic        psel,              // APB select
    input  wire logic        penable,           // APB enable
    input  wire logic        pwrite,            // APB direction
    input  wire logic [7:0]  paddr,             // APB byte address
    input  wire logic [31:0] pwdata,            // APB write data
    output logic      [31:0] prdata,            // APB read data
    output logic             pready,            // APB ready
    output logic             pslverr,           // APB error
    input  wire logic        tck,               // Test clock
    input  wire logic        tms,               // Test mode select
    input  wire logic        tdi,               // Test data in
    output logic             tdo_o,             // Test data out value
    output logic             tdo_oe_n,          // Test data out enable, low drives
    output logic             config_restart_out_o,    // Restart open-drain value
    output logic             config_restart_out_oe_n, // Restart enable, low drives
    output logic             outputs_float,     // Device outputs high-impedance
    output logic             outputs_clamp,     // Device outputs held at clamp
    output logic             oe_reset_o,        // Output-enable/reset line value
    output logic             oe_reset_oe_n,     // Its enable, low drives
    input  wire logic        bsr_tdo,           // Boundary chain serial return
    output logic             bsr_shift,         // Boundary chain shift strobe
    output logic             pattern_read_en    // Array readback permitted
);

    // Software controls, pclk domain
    logic        isp_r;                          // Programming mode
    logic        prot_r;                         // Read protection bit
    logic [31:0] user_r;                         // User code
    logic        ctl_rst_r;                      // Reset-step request level
    logic [2:0]  ack_sync_r;                     // Restart toggle synchroniser
    logic [2:0]  cnt_r;                          // Restart pulse counter
    logic [1:0]  ispq_r;                         // isp into tck domain
    logic [1:0]  prtq_r;                         // prot into tck domain
    logic [1:0]  insq_r [IR_W];                  // Active instruction into pclk
    logic        tgl_r;                          // Restart event toggle, tck domain

    // TAP side, tck domain
    pji_tap_t    st_r, st_nxt;                   // TAP state
    logic [7:0]  sh_r;                           // Instruction shift stage
    logic [7:0]  instruction_shift_reg;          // Active instruction
    logic [31:0] dr_r;                           // Data shift stage
    logic        tdo_r, tdoe_r;                  // Output on falling tck
    pji_dec_t    dec;                            // Decoded active instruction
    logic        apb_wr, apb_rd;                 // APB access strobes

    // Overview of the test port side.
    // The TAP walks sixteen states on tck.
    // Capture loads a fixed pattern plus flags.
    // Shift moves one bit per rising tck.
    // Update makes the new code active.
    // Test-logic-reset restores the id code.
    // Status flags cross into tck by two flops.
    // The active code crosses back into pclk.
    // Restart events cross as a toggle.
    // Software sees the state only over APB.
    // Nothing here runs the flash array itself.
    // Boundary cells live outside this block.
    // Decode shared by shift path and output control
    function automatic pji_dec_t decode(input logic [7:0] c);
        pji_dec_t d;
        d = '0;
        unique case (c)
            INS_EXTEST, INS_SAMPLE: d.bscan = 1'b1;
            INS_CLAMP:    begin d.byp = 1'b1; d.clamp = 1'b1; end
            INS_HIGHZ:    begin d.byp = 1'b1; d.hiz = 1'b1; end
            INS_IDCODE:   d.idc = 1'b1;
            INS_USERCODE: d.usr = 1'b1;
            INS_RESTART:  begin d.byp = 1'b1; d.restart = 1'b1; end
            default:      d.byp = 1'b1;
        endcase
        return d;
    endfunction : decode

    assign dec = decode(instruction_shift_reg);

    // State walk notes.
    // Five tms highs reach reset from anywhere.
    // Idle holds while tms stays low.
    // Pause states let a host stall a scan.
    // Exit-2 may resume the shift.
    // Update-IR commits the scan; update-DR has no effect here.
    // Default guards an illegal one-hot code.
    // Next TAP state
    always_comb begin
        unique case (st_r)
            TLR:  st_nxt = tms ? TLR  : RTI;
            RTI:  st_nxt = tms ? SDRS : RTI;
            SDRS: st_nxt = tms ? SIRS : CDR;
            CDR:  st_nxt = tms ? E1DR : SDR;
            SDR:  st_nxt = tms ? E1DR : SDR;
            E1DR: st_nxt = tms ? UDR  : PDR;
            PDR:  st_nxt = tms ? E2DR : PDR;
            E2DR: st_nxt = tms ? UDR  : SDR;
            UDR:  st_nxt = tms ? SDRS : RTI;
            SIRS: st_nxt = tms ? TLR  : CIR;
            CIR:  st_nxt = tms ? E1IR : SIR;
            SIR:  st_nxt = tms ? E1IR : SIR;
            E1IR: st_nxt = tms ? UIR  : PIR;
            PIR:  st_nxt = tms ? E2IR : PIR;
            E2IR: st_nxt = tms ? UIR  : SIR;
            UIR:  st_nxt = tms ? SDRS : RTI;
            default: st_nxt = TLR;
        endcase
    end

    // Reset hazards.
    // There is no dedicated test reset pin.
    // Bus reset stands in for power-on reset.
    // A host must still send five tms highs,
    // because a glitch on tck can move the TAP.
    // Reset is released while tck stands low,
    // so the first edge sees a settled state.
    // TAP state register; pclk reset doubles as power-on reset
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            st_r <= TLR;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Crossing of the status levels.
    // Both flags change only on bus writes,
    // so plain two-flop synchronisers suffice.
    // A capture in the same tck as a write
    // may show the old flag; that is harmless.
    // The captured flag never feeds decoding.
    // Only the second flop is read.
    // Status levels into tck domain
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            ispq_r <= 2'b00;
            prtq_r <= 2'b00;
        end else begin
            ispq_r <= {ispq_r[0], isp_r};
            prtq_r <= {prtq_r[0], prot_r};
        end
    end

    // Instruction register behaviour.
    // Capture ignores the previous code.
    // Shift enters at the top, leaves at bit 0.
    // The active code changes only at update or reset,
    // so outputs never see a half-shifted code.
    // A restart code flips the event toggle,
    // one flip per update, even if repeated.
    // Reset selects the id code by default.
    // Instruction capture, shift and update
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            sh_r                  <= CAP_BASE;
            instruction_shift_reg <= INS_IDCODE;
            tgl_r                 <= 1'b0;
        end else begin
            if (st_r == CIR) begin
                sh_r               <= CAP_BASE;
                sh_r[CAP_ISP_BIT]  <= ispq_r[1];
                sh_r[CAP_PROT_BIT] <= prtq_r[1];
            end else if (st_r == SIR) begin
                sh_r <= {tdi, sh_r[7:1]};
            end
            if (st_r == TLR) begin
                instruction_shift_reg <= INS_IDCODE;
            end else if (st_r == UIR) begin
                instruction_shift_reg <= sh_r;
                if (sh_r == INS_RESTART) begin
                    tgl_r <= ~tgl_r;
                end
            end
        end
    end

    // Data path notes.
    // Bypass is one bit that captures zero.
    // Id and user code share one 32-bit stage.
    // User code is read while it is stable;
    // software must not write it mid-scan.
    // Unknown codes fall back to bypass.
    // Data register path: bypass, id, user code
    always_ff @(posedge tck or negedge presetn) begin
        if (!presetn) begin
            dr_r <= '0;
        end else if (st_r == CDR) begin
            if (dec.idc) begin
                dr_r <= {ID_VALUE[31:1], 1'b1};
            end else if (dec.usr) begin
                dr_r <= user_r;
            end else begin
                dr_r <= '0;
            end
        end else if (st_r == SDR) begin
            if (dec.idc || dec.usr) begin
                dr_r <= {tdi, dr_r[31:1]};
            end else begin
                dr_r <= {31'h00000000, tdi};
            end
        end
    end

    // Output timing notes.
    // Changing on the falling edge gives the
    // host half a period of setup margin.
    // The pin is released outside shift states,
    // so the board pull-up sets its level.
    // Boundary codes route the chain return.
    // Test data out changes on falling tck
    always_ff @(negedge tck or negedge presetn) begin
        if (!presetn) begin
            tdo_r  <= 1'b1;
            tdoe_r <= 1'b0;
        end else begin
            tdoe_r <= (st_r == SIR) || (st_r == SDR);
            if (st_r == SIR) begin
                tdo_r <= sh_r[0];
            end else if (dec.bscan) begin
                tdo_r <= bsr_tdo;
            end else begin
                tdo_r <= dr_r[0];
            end
        end
    end

    assign tdo_o     = tdo_r;
    assign tdo_oe_n  = ~tdoe_r;
    assign bsr_shift = (st_r == SDR) && dec.bscan;

    // User user_r is reachable only at pclk; tck reads it while stable
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // Control register semantics.
    // Bit 0 enters programming mode and pulls
    // the output-enable/reset line low.
    // Bit 1 sets read protection; it sticks.
    // Bit 2 erases: protection and user code
    // return to their blank values.
    // Erase wins over a protect in one write.
    // User code writes are ignored when locked.
    // Software controls and erase handling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            isp_r     <= 1'b0;
            prot_r    <= 1'b0;
            user_r    <= USERCODE_BLANK;
            ctl_rst_r <= 1'b0;
        end else if (apb_wr && paddr == OFS_CTRL) begin
            isp_r     <= pwdata[CTL_ISP];
            ctl_rst_r <= pwdata[CTL_ISP];
            if (pwdata[CTL_ERASE]) begin
                prot_r <= 1'b0;
                user_r <= USERCODE_BLANK;
            end else if (pwdata[CTL_PROT_SET]) begin
                prot_r <= 1'b1;
            end
        end else if (apb_wr && paddr == OFS_USER && !prot_r) begin
            user_r <= pwdata;
        end
    end

    // Instruction and restart event into pclk domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_sync_r <= 3'b000;
            for (int i = 0; i < IR_W; i++) begin
                insq_r[i] <= 2'b00;
            end
        end else begin
            ack_sync_r <= {ack_sync_r[1:0], tgl_r};
            for (int i = 0; i < IR_W; i++) begin
                insq_r[i] <= {insq_r[i][0], instruction_shift_reg[i]};
            end
        end
    end

    // Restart pulse notes.
    // The toggle edge starts a cycle counter.
    // Length is rounded up to the minimum,
    // trading margin to the maximum for safety.
    // A second event restarts the count.
    // The pin is open-drain; only oe_n moves.
    // Restart pulse of fixed length
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else if (ack_sync_r[2] != ack_sync_r[1]) begin
            cnt_r <= 3'(RST_PULSE_CYC);
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 3'd1;
        end
    end

    // Registered device-side outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_restart_out_o    <= 1'b1;
            config_restart_out_oe_n <= 1'b1;
            outputs_float           <= 1'b0;
            outputs_clamp           <= 1'b0;
            oe_reset_o              <= 1'b1;
            oe_reset_oe_n           <= 1'b1;
            pattern_read_en         <= 1'b1;
        end else begin
            config_restart_out_o    <= 1'b0;
            config_restart_out_oe_n <= !((ack_sync_r[2] != ack_sync_r[1]) || cnt_r > 3'd1);
            outputs_float           <= isp_r
                                       || decode({insq_r[7][1], insq_r[6][1], insq_r[5][1],
                                                  insq_r[4][1], insq_r[3][1], insq_r[2][1],
                                                  insq_r[1][1], insq_r[0][1]}).hiz;
            outputs_clamp           <= decode({insq_r[7][1], insq_r[6][1], insq_r[5][1],
                                               insq_r[4][1], insq_r[3][1], insq_r[2][1],
                                               insq_r[1][1], insq_r[0][1]}).clamp;
            oe_reset_o              <= 1'b0;
            oe_reset_oe_n           <= !ctl_rst_r;
            pattern_read_en         <= !prot_r;
        end
    end

    // Bus slave notes.
    // The setup cycle is decoded and registered,
    // so the access phase has data and ready.
    // Unmapped offsets answer with an error.
    // Status and instruction are read only.
    // Writes act at the access-phase edge.
    // APB slave: zero wait, error on unmapped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == OFS_CTRL || paddr == OFS_STAT
                       || paddr == OFS_USER || paddr == OFS_INS);
            if (apb_rd) begin
                unique case (paddr)
                    OFS_CTRL: prdata <= {29'h0, 1'b0, prot_r, isp_r};
                    OFS_STAT: prdata <= {29'h0, cnt_r != '0, !prot_r, prot_r};
                    OFS_USER: prdata <= user_r;
                    OFS_INS:  prdata <= {24'h0, insq_r[7][1], insq_r[6][1], insq_r[5][1],
                                         insq_r[4][1], insq_r[3][1], insq_r[2][1],
                                         insq_r[1][1], insq_r[0][1]};
                    default:  prdata <= '0;
                endcase
            end
        end
    end

endmodule : pji_top
`default_nettype wire

/* verif/pji_jtag_host.sv */
`timescale 1ns/10ps
`default_nettype none
module pji_jtag_host (
    output logic      tck,     // Test clock, still between frames
    output logic      tms,     // Mode select
    output logic      tdi,     // Serial data to the device
    input  wire logic tdo_o,   // Device serial out
    input  wire logic tdo_oe_n // Low while the device drives
);
    logic tdo_w; // Pin level; a released pin is pulled high
    assign tdo_w = tdo_oe_n ? 1'b1 : tdo_o;
    // Idle levels follow the pin pull-ups
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end
    // One 125 ns test clock; inputs move after the fall, out sampled at the rise
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #62.5;
        q = tdo_w;
        tck = 1'b1;
        #62.5;
        tck = 1'b0;
    endtask : step
    // Five ones reach test-logic-reset whatever the state, then idle
    task automatic reset_tap();
        logic q;
        repeat (5) step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : reset_tap
    // Idle to idle scan of n bits, lowest bit first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        logic q;
        dout = '0;
        step(1'b1, 1'b1, q);
        if (ir)
            step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
        step(1'b0, 1'b1, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
        end
        step(1'b1, 1'b1, q);
        step(1'b0, 1'b1, q);
    endtask : scan
endmodule : pji_jtag_host
`default_nettype wire

/* verif/pji_props.sv */
`timescale 1ns/10ps
`default_nettype none
module pji_props
    import pji_pkg::*;
(
    input wire logic        pclk,                    // Bus clock
    input wire logic        presetn,                 // Async reset, active low
    input wire logic        psel,                    // Bus select
    input wire logic        penable,                 // Bus enable
    input wire logic        pwrite,                  // Bus direction
    input wire logic [7:0]  paddr,                   // Bus address
    input wire logic [31:0] pwdata,                  // Bus write data
    input wire logic        tck,                     // Test clock
    input wire logic        tms,                     // Test mode select
    input wire logic        tdo_oe_n,                // Test out enable
    input wire logic        config_restart_out_o,    // Restart value
    input wire logic        config_restart_out_oe_n, // Restart enable
    input wire logic        outputs_float,           // Outputs floating
    input wire logic        oe_reset_o,              // Reset line value
    input wire logic        oe_reset_oe_n,           // Reset line enable
    input wire logic        pattern_read_en,         // Readback permitted
    input wire logic        bsr_shift                // Boundary chain shift
);
    logic ctl_wr; // Control write completing; the slave has no wait states
    logic ers;    // Full erase written
    assign ctl_wr = psel && penable && pwrite && paddr == OFS_CTRL;
    assign ers    = ctl_wr && pwdata[CTL_ERASE];

    // Restart pulse must fit 300..500 ns of the bus clock
    chk_restart_width: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(config_restart_out_oe_n) |-> (!config_restart_out_oe_n)[*3] ##[1:3]
        config_restart_out_oe_n) else $error("restart pulse width wrong");
    chk_restart_low: assert property (@(posedge pclk) disable iff (!presetn)
        !config_restart_out_oe_n |-> !config_restart_out_o) else $error("restart not low");
    chk_isp_enter: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && pwdata[CTL_ISP] |-> ##[1:2] (!oe_reset_oe_n && !oe_reset_o))
        else $error("reset line not pulled");
    chk_isp_leave: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && !pwdata[CTL_ISP] |-> ##[1:2] oe_reset_oe_n) else $error("reset line held");
    chk_isp_float: assert property (@(posedge pclk) disable iff (!presetn)
        !oe_reset_oe_n |-> outputs_float) else $error("outputs driven in programming");
    chk_prot_set: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_wr && pwdata[CTL_PROT_SET] && !pwdata[CTL_ERASE] |-> ##[1:2] !pattern_read_en)
        else $error("readback not blocked");
    // Only a full erase may lift the protection
    chk_prot_clear: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pattern_read_en) |-> $past(ers) || $past(ers, 2)) else $error("protect lost");
    chk_tap_reset: assert property (@(posedge tck) disable iff (!presetn)
        tms[*5] |=> tdo_oe_n) else $error("test out driven after tap reset");
    chk_bscan_shift: assert property (@(posedge tck) disable iff (!presetn)
        bsr_shift |-> !tdo_oe_n) else $error("boundary shift without test out");
    cov_restart: cover property (@(posedge pclk) $fell(config_restart_out_oe_n));
    cov_isp: cover property (@(posedge pclk) $fell(oe_reset_oe_n));
    cov_erase: cover property (@(posedge pclk) $rose(pattern_read_en));
endmodule : pji_props
`default_nettype wire

/* verif/pji_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e_v, got) begin n_tests++; if ((got) !== (e_v)) begin failures++; \
    $display("ERROR %s expected %h seen %h", nm, e_v, got); end end
module pji_top_tb;
    import pji_pkg::*;
    logic        pclk = 1'b0;     // 10 MHz bus clock
    logic        presetn = 1'b0;  // Reset, active low
    logic        psel = 1'b0;     // Bus select
    logic        penable = 1'b0;  // Bus enable
    logic        pwrite = 1'b0;   // Bus direction
    logic [7:0]  paddr = 8'h00;   // Bus address
    logic [31:0] pwdata = 32'h0;  // Bus write data
    logic [31:0] prdata, rd, so;  // Read data, last read, last scan out
    logic        pready, pslverr, er;           // Handshake, error, last error
    logic        tck, tms, tdi, tdo_o, tdo_oe_n; // Test port
    logic        config_restart_out_o, config_restart_out_oe_n; // Restart pin
    logic        outputs_float, outputs_clamp, oe_reset_o, oe_reset_oe_n, pattern_read_en;
    int          failures = 0, n_tests = 0;     // Mismatch and comparison counts
    logic [7:0]  codes [8] = '{INS_BYPASS, INS_SAMPLE, INS_EXTEST, INS_CLAMP,
                               INS_HIGHZ, INS_IDCODE, INS_USERCODE, 8'h5A};
    // Boundary chain return loops back from the test input
    pji_top pji_top_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .tck, .tms, .tdi, .tdo_o, .tdo_oe_n, .config_restart_out_o,
        .config_restart_out_oe_n, .outputs_float, .outputs_clamp, .oe_reset_o,
        .oe_reset_oe_n, .bsr_tdo(tdi), .bsr_shift(), .pattern_read_en);
    pji_jtag_host pji_jtag_host_inst (.tck, .tms, .tdi, .tdo_o, .tdo_oe_n);
    always #50 pclk = ~pclk;
    // Bus transfer; ends two edges later so registered outputs have settled
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
            failures++;
        repeat (2) @(posedge pclk);
    endtask : apb
    // Instruction scan; waits for the code to cross into the bus clock
    task automatic ir(input logic [7:0] c);
        pji_jtag_host_inst.scan(1'b1, 8, {24'h0, c}, so);
        repeat (4) @(posedge pclk);
    endtask : ir
    task automatic dr(input logic [31:0] d);
        pji_jtag_host_inst.scan(1'b0, 32, d, so);
    endtask : dr
    task automatic t_reset_id();
        dr(32'h0);
        `CHK("idcode", IDCODE_DEF, so)
        `CHK("id lsb", 1'b1, so[0])
        // Sixteen bits through the register show its length and capture
        pji_jtag_host_inst.scan(1'b1, 16, 32'hFEA5, so);
        `CHK("ir length", 32'hA501, so)
        `CHK("tdo idle", 1'b1, tdo_oe_n)
    endtask : t_reset_id
    task automatic t_codes();
        foreach (codes[i]) begin
            ir(codes[i]);
            `CHK("capture", 8'h01, so[7:0])
            apb(1'b0, OFS_INS, 32'h0);
            if (i < 7)
                `CHK("active code", codes[i], rd[7:0])
            `CHK("float", codes[i] == INS_HIGHZ, outputs_float)
            `CHK("clamp", codes[i] == INS_CLAMP, outputs_clamp)
            dr(32'h1);
            if (i == 0 || i == 7)
                `CHK("bypass", 32'h2, so)
            if (i == 5)
                `CHK("id shift", IDCODE_DEF, so)
            if (i == 6)
                `CHK("blank user", USERCODE_BLANK, so)
        end
    endtask : t_codes
    task automatic t_restart();
        int w;
        int n;
        w = 0;
        n = 0;
        pji_jtag_host_inst.scan(1'b1, 8, 32'hEE, so);
        while (config_restart_out_oe_n !== 1'b0 && w < 20) begin
            @(posedge pclk);
            w++;
        end
        `CHK("restart level", 1'b0, config_restart_out_o)
        while (config_restart_out_oe_n === 1'b0 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        `CHK("restart width", 1'b1, n >= 3 && n <= 5)
    endtask : t_restart
    task automatic t_isp();
        apb(1'b1, OFS_CTRL, 32'h1);
        `CHK("reset line", 1'b0, oe_reset_oe_n)
        `CHK("reset low", 1'b0, oe_reset_o)
        `CHK("isp float", 1'b1, outputs_float)
        ir(INS_BYPASS);
        `CHK("isp flag", 8'h11, so[7:0])
        apb(1'b1, OFS_CTRL, 32'h0);
        `CHK("reset release", 1'b1, oe_reset_oe_n)
    endtask : t_isp
    task automatic t_protect();
        apb(1'b1, OFS_USER, 32'h12345678);
        ir(INS_USERCODE);
        dr(32'h0);
        `CHK("usercode", 32'h12345678, so)
        apb(1'b1, OFS_CTRL, 32'h2);
        `CHK("read blocked", 1'b0, pattern_read_en)
        ir(INS_BYPASS);
        `CHK("prot flag", 8'h09, so[7:0])
        apb(1'b1, OFS_CTRL, 32'h0);
        `CHK("prot kept", 1'b0, pattern_read_en)
        apb(1'b1, OFS_CTRL, 32'h4);
        `CHK("erase clears", 1'b1, pattern_read_en)
        ir(INS_USERCODE);
        dr(32'h0);
        `CHK("erased user", USERCODE_BLANK, so)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped", 1'b1, er)
    endtask : t_protect
    task automatic close_out();
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        pji_jtag_host_inst.reset_tap();
        t_reset_id();
        t_codes();
        t_restart();
        t_isp();
        t_protect();
        close_out();
    end
    // Watchdog, ten times the expected run
    initial begin
        #1000000;
        failures++;
        close_out();
    end
endmodule : pji_top_tb
bind pji_top pji_props pji_props_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .tck, .tms, .tdo_oe_n, .config_restart_out_o, .config_restart_out_oe_n,
    .outputs_float, .oe_reset_o, .oe_reset_oe_n, .pattern_read_en, .bsr_shift);
`default_nettype wire
